// ===== rtl/csb_core.v
// Function
// - compares subtract source with borrow, or immediate without borrow; set flags only, one cycle
// - register-bit skip when bit clear or set; pc plus 2 or 3, flags kept
// - I/O-bit skip tests io bit, skips on match, flags kept
// - generic flag branches test chosen status bit; taken target pc plus offset plus one
// - equal branches follow the equal flag
// - borrow, unsigned lower and same-or-higher branches follow the borrow flag
// - minus and plus branches follow the msb flag
// - signed branches follow msb xor overflow
// - nibble-carry branches follow the nibble-carry flag
// - copy-bit branches follow the user copy flag, flags kept
// - overflow branches follow the overflow flag
// - interrupt-state branches follow the armed flag, flags kept
// - indirect load reads memory at pointer in two cycles; post-increment bumps pointer after
// - pre-decrement load decrements pointer first, then reads, two cycles
// - offset load reads pointer plus displacement, pointer kept, two cycles
`timescale 1ns/10ps
`default_nettype none
`include "csb_defs.vh"

module csb_core #(
  parameter DMEM_AW = 8
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i
);

  localparam S_IDLE = 3'b001;
  localparam S_RUN  = 3'b010;
  localparam S_HOLD = 3'b100;

  // ****************************************
  // Storage
  // ****************************************
  reg [7:0]         rf [0:31];
  reg [7:0]         dmem [0:(1<<DMEM_AW)-1];
  reg [2:0]         state;
  reg [15:0]        pc;
  reg [7:0]         flags;
  reg [16:0]        instr;
  reg [1:0]         hold_cnt;
  reg [1:0]         last_cyc;
  reg               last_taken;
  reg               ld_pend;
  reg [15:0]        ld_addr;
  reg [4:0]         ld_dst;
  reg [4:0]         reg_sel;
  reg [DMEM_AW-1:0] mem_addr;
  reg               aw_hold;
  reg               w_hold;
  reg [7:0]         aw_addr;
  reg [31:0]        w_data;
  reg [3:0]         w_strb;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [15:0] ptr_of;
    input [1:0] sel;
    reg   [4:0] lo;
    begin
      lo = `CSB_PTR_BASE + {2'b00, sel, 1'b0};
      ptr_of = {rf[lo + 5'd1], rf[lo]};
    end
  endfunction

  // ****************************************
  // Execute decode
  // ****************************************
  wire [3:0]  op = instr[15:12];
  reg  [15:0] next_pc;
  reg  [7:0]  next_flags;
  reg  [1:0]  cyc;
  reg         taken;
  reg         ld_go;
  reg  [15:0] ld_a;
  reg         ptr_wr;
  reg  [1:0]  ptr_sel;
  reg  [15:0] ptr_new;
  reg  [7:0]  ca;
  reg  [7:0]  cb;
  reg  [8:0]  diff;
  reg  [7:0]  tbyte;
  reg  [15:0] pv;
  reg  [15:0] io_a;

  always @*
  begin
    next_pc    = pc + 16'h0001;
    next_flags = flags;
    cyc        = 2'd1;
    taken      = 1'b0;
    ld_go      = 1'b0;
    ld_a       = 16'h0000;
    ptr_wr     = 1'b0;
    ptr_sel    = instr[3:2];
    ptr_new    = 16'h0000;
    ca         = rf[instr[9:5]];
    cb         = rf[instr[4:0]];
    diff       = 9'h000;
    tbyte      = rf[instr[7:3]];
    pv         = ptr_of(instr[3:2]);
    io_a       = `CSB_IO_BASE + {11'h000, instr[7:3]};
    case (op)
      `CSB_OP_CMP_BORROW, `CSB_OP_CMP_IMM:
      begin
        if (op == `CSB_OP_CMP_IMM)
        begin
          ca = rf[`CSB_IMM_REG_BASE + {1'b0, instr[11:8]}];
          cb = instr[7:0];
        end
        diff = {1'b0, ca} - {1'b0, cb}
             - {8'h00, (op == `CSB_OP_CMP_BORROW) & flags[`CSB_FLG_BORROW]};
        next_flags[`CSB_FLG_BORROW] = diff[8];
        // Borrow variant keeps equal only if it already held, for multi-byte compares
        next_flags[`CSB_FLG_EQUAL]  = (diff[7:0] == 8'h00)
                                    & ((op == `CSB_OP_CMP_IMM) | flags[`CSB_FLG_EQUAL]);
        next_flags[`CSB_FLG_MSB]    = diff[7];
        next_flags[`CSB_FLG_SPILL]  = (ca[7] & ~cb[7] & ~diff[7]) | (~ca[7] & cb[7] & diff[7]);
        next_flags[`CSB_FLG_SIGN]   = diff[7] ^ next_flags[`CSB_FLG_SPILL];
        next_flags[`CSB_FLG_NIBBLE] = (~ca[3] & cb[3]) | (cb[3] & diff[3]) | (diff[3] & ~ca[3]);
      end
      `CSB_OP_SKIP_RCLR, `CSB_OP_SKIP_RSET, `CSB_OP_SKIP_ICLR, `CSB_OP_SKIP_ISET:
      begin
        if (op == `CSB_OP_SKIP_ICLR || op == `CSB_OP_SKIP_ISET)
          tbyte = dmem[io_a[DMEM_AW-1:0]];
        // Set forms are the even opcodes 4 and 6
        if (tbyte[instr[2:0]] == ~op[0])
        begin
          taken   = 1'b1;
          next_pc = pc + (instr[`CSB_INSTR_TWO_WORD] ? 16'h0003 : 16'h0002);
          cyc     = instr[`CSB_INSTR_TWO_WORD] ? 2'd3 : 2'd2;
        end
      end
      `CSB_OP_BR_SET, `CSB_OP_BR_CLR:
      begin
        // One path serves every flag alias: equal, borrow, msb, sign, nibble,
        // copy, overflow and armed; signed forms use the sign bit
        if (flags[instr[2:0]] == (op == `CSB_OP_BR_SET))
        begin
          taken   = 1'b1;
          next_pc = pc + {{9{instr[9]}}, instr[9:3]} + 16'h0001;
          cyc     = 2'd2;
        end
      end
      `CSB_OP_LOAD:
      begin
        ld_go = 1'b1;
        cyc   = 2'd2;
        if (instr[1:0] == `CSB_LD_PREDEC)
        begin
          ptr_wr  = 1'b1;
          ptr_new = pv - 16'h0001;
          ld_a    = ptr_new;
        end
        else
        begin
          ptr_wr  = (instr[1:0] == `CSB_LD_POSTINC);
          ptr_new = pv + 16'h0001;
          ld_a    = pv;
        end
      end
      `CSB_OP_LOAD_OFS:
      begin
        ld_go   = 1'b1;
        cyc     = 2'd2;
        // Bit 6 picks the second or third pair; the fourth code has no pair
        ptr_sel = {instr[6], ~instr[6]};
        ld_a    = ptr_of({instr[6], ~instr[6]}) + {10'h000, instr[5:0]};
      end
      default:
      begin
        cyc = 2'd1;
      end
    endcase
  end

  // ****************************************
  // Bus slave
  // ****************************************
  wire busy     = ~state[0];
  wire do_write = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire start    = do_write & (aw_addr == `CSB_OFF_INSTR) & ~busy;
  wire rd_take  = s_axi_arvalid_i & ~s_axi_rvalid_o;

  assign s_axi_awready_o = ~aw_hold & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_hold & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  wire   rf_bus_wr  = do_write & (aw_addr == `CSB_OFF_REG_DATA) & w_strb[0];
  wire   mem_bus_wr = do_write & (aw_addr == `CSB_OFF_MEM_DATA) & w_strb[0];
  wire   run_ptr    = state[1] & ptr_wr;
  wire   hold_ld    = state[2] & ld_pend;

  // Merged words are cut to each register's width on purpose
  wire [31:0] instr_mrg = merge({15'h0000, instr}, w_data, w_strb);
  wire [31:0] pc_mrg    = merge({16'h0000, pc}, w_data, w_strb);
  wire [31:0] maddr_mrg = merge({{(32-DMEM_AW){1'b0}}, mem_addr}, w_data, w_strb);

  reg    known_wr;
  reg    known_rd;
  reg [31:0] rd_val;

  always @*
  begin
    known_wr = 1'b1;
    if (aw_addr == `CSB_OFF_INSTR)
      known_wr = ~busy;
    else if (aw_addr == `CSB_OFF_STATUS)
      known_wr = 1'b0;
    else if (aw_addr > `CSB_OFF_MEM_DATA || aw_addr[1:0] != 2'b00)
      known_wr = 1'b0;
  end

  always @*
  begin
    known_rd = 1'b1;
    rd_val   = 32'h0000_0000;
    if (s_axi_araddr_i == `CSB_OFF_INSTR)
      rd_val = {15'h0000, instr};
    else if (s_axi_araddr_i == `CSB_OFF_STATUS)
      rd_val = {27'h0000000, last_taken, last_cyc, 1'b0, busy};
    else if (s_axi_araddr_i == `CSB_OFF_PC)
      rd_val = {16'h0000, pc};
    else if (s_axi_araddr_i == `CSB_OFF_FLAGS)
      rd_val = {24'h000000, flags};
    else if (s_axi_araddr_i == `CSB_OFF_REG_SEL)
      rd_val = {27'h0000000, reg_sel};
    else if (s_axi_araddr_i == `CSB_OFF_REG_DATA)
      rd_val = {24'h000000, rf[reg_sel]};
    else if (s_axi_araddr_i == `CSB_OFF_MEM_ADDR)
      rd_val = {{(32-DMEM_AW){1'b0}}, mem_addr};
    else if (s_axi_araddr_i == `CSB_OFF_MEM_DATA)
      rd_val = {24'h000000, dmem[mem_addr]};
    else
      known_rd = 1'b0;
  end

  // Arrays carry no reset; software loads them before starting
  always @(posedge clk_i)
  begin
    if (hold_ld)
      rf[ld_dst] <= dmem[ld_addr[DMEM_AW-1:0]];
    else if (rf_bus_wr)
      rf[reg_sel] <= w_data[7:0];
    // Pointer write lands in the first cycle, so pre-decrement reads the new value
    if (run_ptr)
    begin
      rf[`CSB_PTR_BASE + {2'b00, ptr_sel, 1'b0}]        <= ptr_new[7:0];
      rf[`CSB_PTR_BASE + {2'b00, ptr_sel, 1'b0} + 5'd1] <= ptr_new[15:8];
    end
    if (mem_bus_wr)
      dmem[mem_addr] <= w_data[7:0];
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold        <= 1'b0;
      w_hold         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `CSB_RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `CSB_RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
      reg_sel        <= 5'd0;
      mem_addr       <= {DMEM_AW{1'b0}};
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= known_wr ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
        if (aw_addr == `CSB_OFF_REG_SEL && w_strb[0])
          reg_sel <= w_data[4:0];
        if (aw_addr == `CSB_OFF_MEM_ADDR)
          mem_addr <= maddr_mrg[DMEM_AW-1:0];
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_val;
        s_axi_rresp_o  <= known_rd ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= S_IDLE;
      pc         <= `CSB_PC_RST;
      flags      <= `CSB_FLAGS_RST;
      instr      <= 17'h00000;
      hold_cnt   <= 2'd0;
      last_cyc   <= 2'd0;
      last_taken <= 1'b0;
      ld_pend    <= 1'b0;
      ld_addr    <= 16'h0000;
      ld_dst     <= 5'd0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            instr <= instr_mrg[16:0];
            state <= S_RUN;
          end
          else if (do_write && aw_addr == `CSB_OFF_PC)
            pc <= pc_mrg[15:0];
          else if (do_write && aw_addr == `CSB_OFF_FLAGS && w_strb[0])
            flags <= w_data[7:0];
        end
        S_RUN:
        begin
          pc         <= next_pc;
          flags      <= next_flags;
          last_cyc   <= cyc;
          last_taken <= taken;
          ld_pend    <= ld_go;
          ld_addr    <= ld_a;
          ld_dst     <= (op == `CSB_OP_LOAD_OFS) ? instr[11:7] : instr[8:4];
          hold_cnt   <= cyc - 2'd1;
          state      <= (cyc == 2'd1) ? S_IDLE : S_HOLD;
        end
        S_HOLD:
        begin
          ld_pend  <= 1'b0;
          hold_cnt <= hold_cnt - 2'd1;
          if (hold_cnt == 2'd1)
            state <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== shared/csb_defs.vh
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CSB_OFF_INSTR     8'h00
`define CSB_OFF_STATUS    8'h04
`define CSB_OFF_PC        8'h08
`define CSB_OFF_FLAGS     8'h0c
`define CSB_OFF_REG_SEL   8'h10
`define CSB_OFF_REG_DATA  8'h14
`define CSB_OFF_MEM_ADDR  8'h18
`define CSB_OFF_MEM_DATA  8'h1c

// ****************************************
// Field positions and reset values
// ****************************************
`define CSB_INSTR_TWO_WORD 16
`define CSB_STAT_BUSY      0
`define CSB_STAT_TAKEN     4
`define CSB_PC_RST         16'h0000
`define CSB_FLAGS_RST      8'h00

// ****************************************
// Status flag positions
// ****************************************
`define CSB_FLG_BORROW 0
`define CSB_FLG_EQUAL  1
`define CSB_FLG_MSB    2
`define CSB_FLG_SPILL  3
`define CSB_FLG_SIGN   4
`define CSB_FLG_NIBBLE 5
`define CSB_FLG_COPY   6
`define CSB_FLG_ARMED  7

// ****************************************
// Instruction classes, bits 15:12
// ****************************************
`define CSB_OP_CMP_BORROW 4'h1
`define CSB_OP_CMP_IMM    4'h2
`define CSB_OP_SKIP_RCLR  4'h3
`define CSB_OP_SKIP_RSET  4'h4
`define CSB_OP_SKIP_ICLR  4'h5
`define CSB_OP_SKIP_ISET  4'h6
`define CSB_OP_BR_SET     4'h7
`define CSB_OP_BR_CLR     4'h8
`define CSB_OP_LOAD       4'ha
`define CSB_OP_LOAD_OFS   4'hb

// Load addressing modes, pointer pair base, immediate register base and I/O base
`define CSB_LD_PLAIN      2'd0
`define CSB_LD_POSTINC    2'd1
`define CSB_LD_PREDEC     2'd2
`define CSB_PTR_BASE      5'd26
`define CSB_IMM_REG_BASE  5'd16
`define CSB_IO_BASE       16'h0020

// Bus responses
`define CSB_RESP_OKAY     2'b00
`define CSB_RESP_SLVERR   2'b10

`endif

// ===== verif/csb_core_props.sv
`timescale 1ns/10ps
`default_nettype none

module csb_core_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Host offers address and data together, so both land on one edge
  wire aw_w = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o;
  wire ar_t = s_axi_arvalid_i & s_axi_arready_o;

  AST_B_LATENCY: assert property (aw_w |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write answer not two edges after take");
  AST_B_STANDS: assert property (s_axi_bvalid_o & !s_axi_bready_i |=>
    s_axi_bvalid_o & $stable(s_axi_bresp_o)) else $error("write answer dropped early");
  AST_B_ENDS: assert property (s_axi_bvalid_o & s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer outlived ready");
  AST_B_BLOCKS: assert property (s_axi_bvalid_o |-> !s_axi_awready_o & !s_axi_wready_o)
    else $error("write taken during answer");
  AST_R_LATENCY: assert property (ar_t |=> s_axi_rvalid_o)
    else $error("read answer late");
  AST_R_STANDS: assert property (s_axi_rvalid_o & !s_axi_rready_i |=>
    s_axi_rvalid_o & $stable(s_axi_rdata_o)) else $error("read answer dropped early");
  AST_R_ENDS: assert property (s_axi_rvalid_o & s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer outlived ready");
  AST_R_BLOCKS: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during answer");

  cover property (aw_w);
  cover property (ar_t);
  cover property (s_axi_bvalid_o & s_axi_bresp_o == 2'b10);
endmodule

bind csb_core csb_core_props u_props (.*);
`default_nettype wire

// ===== verif/csb_host.sv
`timescale 1ns/10ps
`default_nettype none

// Software side of the register bus; pins carry the core's names so the
// bench wires both ends by name. slow_i holds ready off to stretch answers.
module csb_host (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  output logic [7:0]       s_axi_awaddr_i = 8'h00,
  output logic             s_axi_awvalid_i = 1'b0,
  input  wire logic        s_axi_awready_o,
  output logic [31:0]      s_axi_wdata_i = 32'h0,
  output logic [3:0]       s_axi_wstrb_i = 4'hf,
  output logic             s_axi_wvalid_i = 1'b0,
  input  wire logic        s_axi_wready_o,
  input  wire logic [1:0]  s_axi_bresp_o,
  input  wire logic        s_axi_bvalid_o,
  output logic             s_axi_bready_i = 1'b0,
  output logic [7:0]       s_axi_araddr_i = 8'h00,
  output logic             s_axi_arvalid_i = 1'b0,
  input  wire logic        s_axi_arready_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic [1:0]  s_axi_rresp_o,
  input  wire logic        s_axi_rvalid_o,
  output logic             s_axi_rready_i = 1'b0
);
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= !slow_i;
      do
      begin
        @(posedge clk_i);
        if (s_axi_awready_o)
          s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o)
          s_axi_wvalid_i <= 1'b0;
        if (s_axi_bvalid_o & !s_axi_bready_i)
          s_axi_bready_i <= 1'b1;
      end
      while (!(s_axi_bvalid_o & s_axi_bready_i));
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= !slow_i;
      do
      begin
        @(posedge clk_i);
        if (s_axi_arready_o)
          s_axi_arvalid_i <= 1'b0;
        if (s_axi_rvalid_o & !s_axi_rready_i)
          s_axi_rready_i <= 1'b1;
      end
      while (!(s_axi_rvalid_o & s_axi_rready_i));
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "csb_defs.vh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0s exp %h got %h", nm, e, a); end end

module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        slow_i = 1'b0;
  wire  [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  wire  [31:0] s_axi_wdata_i, s_axi_rdata_o;
  wire  [3:0]  s_axi_wstrb_i;
  wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire         s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  wire         s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  wire         s_axi_rvalid_o, s_axi_rready_i;
  integer      err_total = 0;
  integer      n_checks = 0;
  integer      s;
  logic [31:0] v;
  logic [1:0]  r;

  always #20 clk_i = ~clk_i;

  csb_core dut (.*);
  csb_host host (.*);

  task wreg(input [7:0] a, input [31:0] d);
    begin
      host.wr(a, d, r);
      `CHK("bresp", `CSB_RESP_OKAY, r)
    end
  endtask

  task rchk(input [7:0] a, input [31:0] e);
    begin
      host.rd(a, v, r);
      `CHK($sformatf("reg %h", a), e, v)
    end
  endtask

  // Select register then data word at the next offset
  task setr(input [7:0] a, input [7:0] n, input [7:0] d);
    begin
      wreg(a, {24'h0, n});
      wreg(a + 8'h04, {24'h0, d});
    end
  endtask

  task getr(input [7:0] n, input [7:0] e);
    begin
      wreg(`CSB_OFF_REG_SEL, {24'h0, n});
      rchk(`CSB_OFF_REG_DATA, {24'h0, e});
    end
  endtask

  // Taken flag 2 means not judged
  task run(input [16:0] i, input [15:0] pc0, input [15:0] pce, input [1:0] cyc,
           input [1:0] tk);
    integer n;
    begin
      wreg(`CSB_OFF_PC, {16'h0, pc0});
      wreg(`CSB_OFF_INSTR, {15'h0, i});
      v = 32'h1;
      for (n = 0; n < 20 && v[0]; n++)
        host.rd(`CSB_OFF_STATUS, v, r);
      `CHK("busy", 1'b0, v[0])
      `CHK("cycles", cyc, v[3:2])
      if (tk != 2'd2)
        `CHK("taken", tk[0], v[4])
      rchk(`CSB_OFF_PC, {16'h0, pce});
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    setr(`CSB_OFF_REG_SEL, 8'd16, 8'h05);
    setr(`CSB_OFF_REG_SEL, 8'd17, 8'h04);
    wreg(`CSB_OFF_FLAGS, 32'hc0);
    run(17'h02005, 16'h0, 16'h1, 2'd1, 2'd2);
    rchk(`CSB_OFF_FLAGS, 32'hc2);
    run(17'h02006, 16'h1, 16'h2, 2'd1, 2'd2);
    rchk(`CSB_OFF_FLAGS, 32'hf5);
    // Old equal set so a dropped borrow shows as a cleared equal
    wreg(`CSB_OFF_FLAGS, 32'hc3);
    run(17'h01211, 16'h2, 16'h3, 2'd1, 2'd2);
    rchk(`CSB_OFF_FLAGS, 32'hc2);
    getr(8'd16, 8'h05);
    for (s = 0; s < 8; s++)
    begin
      wreg(`CSB_OFF_FLAGS, 32'h1 << s);
      run({14'h0e7d, s[2:0]}, 16'h10, 16'h0e, 2'd2, 2'd1);
      run({14'h107d, s[2:0]}, 16'h10, 16'h11, 2'd1, 2'd0);
      wreg(`CSB_OFF_FLAGS, {24'h0, ~(8'h1 << s[2:0])});
      run({14'h1005, s[2:0]}, 16'h10, 16'h16, 2'd2, 2'd1);
      run({14'h0e05, s[2:0]}, 16'h10, 16'h11, 2'd1, 2'd0);
      rchk(`CSB_OFF_FLAGS, {24'h0, ~(8'h1 << s[2:0])});
    end
    slow_i <= 1'b1;
    setr(`CSB_OFF_REG_SEL, 8'd5, 8'h08);
    setr(`CSB_OFF_MEM_ADDR, 8'h22, 8'h01);
    wreg(`CSB_OFF_FLAGS, 32'h5a);
    run(17'h1402b, 16'h10, 16'h13, 2'd3, 2'd1);
    run(17'h0302b, 16'h10, 16'h11, 2'd1, 2'd0);
    run(17'h03028, 16'h10, 16'h12, 2'd2, 2'd1);
    run(17'h06010, 16'h10, 16'h12, 2'd2, 2'd1);
    run(17'h15011, 16'h10, 16'h13, 2'd3, 2'd1);
    run(17'h05010, 16'h10, 16'h11, 2'd1, 2'd0);
    setr(`CSB_OFF_REG_SEL, 8'd26, 8'h40);
    setr(`CSB_OFF_REG_SEL, 8'd27, 8'h00);
    setr(`CSB_OFF_REG_SEL, 8'd28, 8'h30);
    setr(`CSB_OFF_REG_SEL, 8'd29, 8'h00);
    setr(`CSB_OFF_MEM_ADDR, 8'h40, 8'ha5);
    setr(`CSB_OFF_MEM_ADDR, 8'h41, 8'h3c);
    setr(`CSB_OFF_MEM_ADDR, 8'h35, 8'h77);
    run(17'h0a011, 16'h20, 16'h21, 2'd2, 2'd2);
    getr(8'd1, 8'ha5);
    getr(8'd26, 8'h41);
    run(17'h0a022, 16'h21, 16'h22, 2'd2, 2'd2);
    getr(8'd2, 8'ha5);
    getr(8'd26, 8'h40);
    run(17'h0b185, 16'h22, 16'h23, 2'd2, 2'd2);
    getr(8'd3, 8'h77);
    getr(8'd28, 8'h30);
    setr(`CSB_OFF_REG_SEL, 8'd30, 8'h35);
    setr(`CSB_OFF_REG_SEL, 8'd31, 8'h00);
    run(17'h0a048, 16'h23, 16'h24, 2'd2, 2'd2);
    getr(8'd4, 8'h77);
    getr(8'd30, 8'h35);
    run(17'h0b34b, 16'h24, 16'h25, 2'd2, 2'd2);
    getr(8'd6, 8'ha5);
    getr(8'd30, 8'h35);
    rchk(`CSB_OFF_FLAGS, 32'h5a);
    host.wr(`CSB_OFF_STATUS, 32'h1, r);
    `CHK("status write", `CSB_RESP_SLVERR, r)
    host.rd(8'h20, v, r);
    `CHK("unmapped resp", `CSB_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, v)
    report_and_stop;
  end

  // Whole run is about a thousand cycles; this bound is far beyond it
  initial
  begin
    #2000000;
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
